// ===== logic/sdc_pkg.sv
package sdc_pkg;
   // ****************
   // Commands and states
   // ****************
   typedef enum logic [3:0] {
      CMD_NONE, CMD_DESEL, CMD_IDLE, CMD_CFG, CMD_REF, CMD_PRE, CMD_CLOSE_ALL_ROWS, CMD_ACT,
      CMD_RD, CMD_WR, CMD_ZQL, CMD_ZQS, CMD_SRE, CMD_SRX, CMD_PDE, CMD_PDX
   } sdc_cmd_t;

   typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_PD, ST_SELF_REF} sdc_state_t;

   // ****************
   // Carriers
   // ****************
   typedef struct packed {
      logic       cs_n;
      logic       row_open_flag_n;
      logic       ras_a16;
      logic       cas_a15;
      logic       we_a14;
      logic       clock_gate;
      logic [1:0] group_pick;
      logic [1:0] bank_slot;
      logic       auto_close_bit;
      logic       chop_select_bit;
      logic [2:0] column_addr;
      logic       termination_control;
   } sdc_pins_t;

   typedef struct packed {
      logic       burst_interleave;
      logic [1:0] burst_len_mode;
   } sdc_cfg_t;

   typedef struct packed {
      logic idle;
      logic power_down;
      logic pd_precharge;
      logic self_refresh;
   } sdc_status_t;

   // ****************
   // Encodings, positions, counts
   // ****************
   localparam logic [1:0] BL_FIXED8     = 2'h0;
   localparam logic [1:0] BL_OTF        = 2'h1;
   localparam logic [1:0] BL_FIXED4     = 2'h2;
   localparam logic [2:0] OP_CFG        = 3'h0;
   localparam logic [2:0] OP_REF        = 3'h1;
   localparam logic [2:0] OP_PRE        = 3'h2;
   localparam logic [2:0] OP_WR         = 3'h4;
   localparam logic [2:0] OP_RD         = 3'h5;
   localparam logic [2:0] OP_ZQ         = 3'h6;
   localparam logic [2:0] OP_IDLE       = 3'h7;
   localparam logic [2:0] BEAT_LAST     = 3'h7;
   localparam logic [2:0] WR_CORE_FULL  = 3'h7;
   localparam logic [2:0] WR_CORE_CHOP  = 3'h5;
   localparam int         CLK_PERIOD_NS = 100;
   localparam int         REFRESH_NS    = 350;
   localparam int         ZQ_LONG_NS    = 1000;
   localparam int         ZQ_SHORT_NS   = 200;
   localparam int         SR_EXIT_NS    = 360;
   localparam logic [7:0] REFRESH_CYC   = 8'((REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] ZQ_LONG_CYC   = 8'((ZQ_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] ZQ_SHORT_CYC  = 8'((ZQ_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] SR_EXIT_CYC   = 8'((SR_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : sdc_pkg

// ===== logic/sdc_cmd_decode.sv
`timescale 1ns/1ns
// Overview of operation
// - Decode command pins at each link edge
// - Flag low turns strobes into row bits
// - Strobe pattern picks read/write, auto close
// - Chop bit picks four or eight beats
// - Group and slot pick bank or config
// - Started bursts always run to completion
// - No array refresh while powered down
// - Termination ignored in decode, off in self refresh
// - Self refresh only from idle with refresh
// - Power-down kind follows banks at end
// - Idle needs closed banks, no burst, delays done
// - Clock gate edge pair picks state action
// - Config bit picks sequential or interleaved reads
// - Two-bit field picks burst length mode
// - Chopped read orders within group of four
// - Unused chopped read beats are high impedance
// - Full read wraps halves, full write starts zero
// - Fixed chop starts internal write earlier
module sdc_cmd_decode (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 link_clk,
   input  wire logic                 reset_n,
   input  wire sdc_pkg::sdc_pins_t   pins,
   input  wire sdc_pkg::sdc_cfg_t    cfg,
   output sdc_pkg::sdc_cmd_t         cmd_ff,
   output logic [3:0]                cmd_bank_ff,
   output logic                      cfg_write_ff,
   output logic [2:0]                cfg_sel_ff,
   output logic                      array_refresh_ff,
   output logic [2:0]                beat_word_ff,
   output logic                      beat_valid_ff,
   output logic                      data_hiz_ff,
   output logic                      wr_core_start_ff,
   output logic                      term_active_ff,
   output sdc_pkg::sdc_status_t      status_ff
);
   // ****************
   // State
   // ****************
   typedef struct packed {
      sdc_pkg::sdc_cfg_t    cfg_s1;
      sdc_pkg::sdc_cfg_t    cfg_s2;
      sdc_pkg::sdc_pins_t   pins;
      logic                 prev_gate;
      sdc_pkg::sdc_cmd_t    cmd;
      logic [3:0]           bank;
      sdc_pkg::sdc_state_t  state;
      logic [15:0]          banks;
      logic [7:0]           timer;
      logic                 busy;
      logic [2:0]           beat;
      logic [2:0]           start;
      logic                 chop;
      logic                 fixed4;
      logic                 is_wr;
      logic                 interleave;
      logic                 autoclose;
      logic [3:0]           close_bank;
      logic [2:0]           word;
      logic                 word_valid;
      logic                 data_hiz;
      logic                 wr_core_start;
      logic                 refresh;
      logic                 cfg_wr;
      logic [2:0]           cfg_sel;
      logic                 term;
      logic                 idle;
   } sdc_link_t;

   typedef struct packed {
      sdc_pkg::sdc_status_t s1;
      sdc_pkg::sdc_status_t s2;
      sdc_pkg::sdc_status_t s3;
   } sdc_core_t;

   sdc_link_t          r_ff;
   sdc_link_t          nxt_r;
   sdc_core_t          c_ff;
   sdc_core_t          nxt_c;
   sdc_pkg::sdc_cmd_t  cmd;
   logic               idle_now;
   logic               ld;
   logic               lrst;

   // Pin reset is asynchronous too; both drive the link domain
   assign lrst = rst | ~reset_n;

   // ****************
   // Link domain
   // ****************
   always_comb begin
      sdc_pkg::sdc_pins_t p;
      logic [2:0]         op;
      logic [3:0]         bk;
      p   = r_ff.pins;
      op  = {p.ras_a16, p.cas_a15, p.we_a14};
      bk  = {p.group_pick, p.bank_slot};
      nxt_r = r_ff;
      nxt_r.cfg_s1 = cfg;
      nxt_r.cfg_s2 = r_ff.cfg_s1;
      nxt_r.pins = pins;
      nxt_r.prev_gate = r_ff.pins.clock_gate;
      nxt_r.wr_core_start = 1'b0;
      nxt_r.refresh = 1'b0;
      nxt_r.cfg_wr = 1'b0;
      nxt_r.word_valid = 1'b0;
      nxt_r.data_hiz = 1'b0;
      if (r_ff.timer != 8'h00) begin
         nxt_r.timer = r_ff.timer - 8'h01;
      end

      // Termination pin never reaches the decode below
      cmd = sdc_pkg::CMD_NONE;
      if (r_ff.prev_gate && p.clock_gate) begin
         if (p.cs_n) begin
            cmd = sdc_pkg::CMD_DESEL;
         end else if (!p.row_open_flag_n) begin
            cmd = sdc_pkg::CMD_ACT;
         end else begin
            case (op)
               sdc_pkg::OP_CFG:  cmd = sdc_pkg::CMD_CFG;
               sdc_pkg::OP_REF:  cmd = sdc_pkg::CMD_REF;
               sdc_pkg::OP_PRE:  cmd = p.auto_close_bit ? sdc_pkg::CMD_CLOSE_ALL_ROWS : sdc_pkg::CMD_PRE;
               sdc_pkg::OP_WR:   cmd = sdc_pkg::CMD_WR;
               sdc_pkg::OP_RD:   cmd = sdc_pkg::CMD_RD;
               sdc_pkg::OP_ZQ:   cmd = p.auto_close_bit ? sdc_pkg::CMD_ZQL : sdc_pkg::CMD_ZQS;
               sdc_pkg::OP_IDLE: cmd = sdc_pkg::CMD_IDLE;
               default:          cmd = sdc_pkg::CMD_NONE;
            endcase
         end
      end else if (r_ff.prev_gate && !p.clock_gate) begin
         if (!p.cs_n && p.row_open_flag_n && op == sdc_pkg::OP_REF) begin
            cmd = sdc_pkg::CMD_SRE;
         end else if (p.cs_n) begin
            cmd = sdc_pkg::CMD_PDE;
         end
      end else if (!r_ff.prev_gate && p.clock_gate) begin
         if (r_ff.state == sdc_pkg::ST_SELF_REF) begin
            // Idle command accepted too, for gear-down style exits
            if (p.cs_n || (p.row_open_flag_n && op == sdc_pkg::OP_IDLE)) begin
               cmd = sdc_pkg::CMD_SRX;
            end
         end else if (p.cs_n) begin
            cmd = sdc_pkg::CMD_PDX;
         end
      end

      idle_now = (r_ff.banks == 16'h0000) && !r_ff.busy && (r_ff.timer == 8'h00) &&
                 r_ff.prev_gate && (r_ff.state == sdc_pkg::ST_IDLE);
      ld = (cmd == sdc_pkg::CMD_RD || cmd == sdc_pkg::CMD_WR) &&
           (!r_ff.busy || r_ff.beat == sdc_pkg::BEAT_LAST);

      // Burst engine, one column word per link edge
      if (r_ff.busy) begin
         nxt_r.word_valid = !(r_ff.chop && r_ff.beat[2]);
         nxt_r.data_hiz = r_ff.chop && r_ff.beat[2] && !r_ff.is_wr;
         if (r_ff.is_wr) begin
            nxt_r.word = r_ff.chop ? {r_ff.start[2], r_ff.beat[1:0]} : r_ff.beat;
         end else if (r_ff.interleave) begin
            nxt_r.word = r_ff.start ^ r_ff.beat;
         end else begin
            nxt_r.word = {r_ff.start[2] ^ r_ff.beat[2],
                          2'(r_ff.start[1:0] + r_ff.beat[1:0])};
         end
         if (r_ff.is_wr && r_ff.beat == (r_ff.fixed4 ? sdc_pkg::WR_CORE_CHOP
                                                     : sdc_pkg::WR_CORE_FULL)) begin
            nxt_r.wr_core_start = 1'b1;
         end
         nxt_r.beat = 3'(r_ff.beat + 3'h1);
         if (r_ff.beat == sdc_pkg::BEAT_LAST) begin
            nxt_r.busy = 1'b0;
            if (r_ff.autoclose) begin
               nxt_r.banks[r_ff.close_bank] = 1'b0;
            end
         end
      end

      nxt_r.cmd = cmd;
      if (cmd != sdc_pkg::CMD_NONE && cmd != sdc_pkg::CMD_DESEL) begin
         nxt_r.bank = bk;
      end
      case (cmd)
         sdc_pkg::CMD_ACT: begin
            nxt_r.banks[bk] = 1'b1;
         end
         sdc_pkg::CMD_PRE: begin
            nxt_r.banks[bk] = 1'b0;
         end
         sdc_pkg::CMD_CLOSE_ALL_ROWS: begin
            nxt_r.banks = 16'h0000;
         end
         sdc_pkg::CMD_RD, sdc_pkg::CMD_WR: begin
            if (ld) begin
               nxt_r.busy = 1'b1;
               nxt_r.beat = 3'h0;
               nxt_r.start = p.column_addr;
               nxt_r.is_wr = (cmd == sdc_pkg::CMD_WR);
               nxt_r.autoclose = p.auto_close_bit;
               nxt_r.close_bank = bk;
               nxt_r.interleave = r_ff.cfg_s2.burst_interleave;
               nxt_r.fixed4 = (r_ff.cfg_s2.burst_len_mode == sdc_pkg::BL_FIXED4);
               case (r_ff.cfg_s2.burst_len_mode)
                  sdc_pkg::BL_FIXED4: nxt_r.chop = 1'b1;
                  sdc_pkg::BL_OTF:    nxt_r.chop = !p.chop_select_bit;
                  default:            nxt_r.chop = 1'b0;
               endcase
            end
         end
         sdc_pkg::CMD_CFG: begin
            nxt_r.cfg_wr = 1'b1;
            nxt_r.cfg_sel = {p.group_pick[0], p.bank_slot};
         end
         sdc_pkg::CMD_REF: begin
            // A stray refresh that slips past a bad power-down exit is dropped
            nxt_r.refresh = (r_ff.state != sdc_pkg::ST_PD);
            nxt_r.timer = sdc_pkg::REFRESH_CYC;
         end
         sdc_pkg::CMD_ZQL: begin
            nxt_r.timer = sdc_pkg::ZQ_LONG_CYC;
         end
         sdc_pkg::CMD_ZQS: begin
            nxt_r.timer = sdc_pkg::ZQ_SHORT_CYC;
         end
         sdc_pkg::CMD_SRE: begin
            // Refused unless idle; a busy device treats it as power-down
            nxt_r.state = idle_now ? sdc_pkg::ST_SELF_REF : sdc_pkg::ST_PD;
         end
         sdc_pkg::CMD_PDE: begin
            nxt_r.state = sdc_pkg::ST_PD;
         end
         sdc_pkg::CMD_PDX: begin
            nxt_r.state = sdc_pkg::ST_ACTIVE;
         end
         sdc_pkg::CMD_SRX: begin
            nxt_r.state = sdc_pkg::ST_ACTIVE;
            nxt_r.timer = sdc_pkg::SR_EXIT_CYC;
         end
         default: begin
         end
      endcase
      if (nxt_r.state == sdc_pkg::ST_IDLE || nxt_r.state == sdc_pkg::ST_ACTIVE) begin
         nxt_r.state = (nxt_r.banks == 16'h0000) ? sdc_pkg::ST_IDLE : sdc_pkg::ST_ACTIVE;
      end
      nxt_r.term = p.termination_control && (nxt_r.state != sdc_pkg::ST_SELF_REF);
      nxt_r.idle = (nxt_r.banks == 16'h0000) && !nxt_r.busy && (nxt_r.timer == 8'h00) &&
                   p.clock_gate && (nxt_r.state == sdc_pkg::ST_IDLE);
   end

   always_ff @(posedge link_clk or posedge lrst) begin
      if (lrst) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ****************
   // Core domain status, each bit a level through three flops
   // ****************
   always_comb begin
      nxt_c = c_ff;
      nxt_c.s1.idle = r_ff.idle;
      nxt_c.s1.power_down = (r_ff.state == sdc_pkg::ST_PD);
      nxt_c.s1.pd_precharge = (r_ff.state == sdc_pkg::ST_PD) && (r_ff.banks == 16'h0000);
      nxt_c.s1.self_refresh = (r_ff.state == sdc_pkg::ST_SELF_REF);
      nxt_c.s2 = c_ff.s1;
      // Only a pattern seen on two samples moves on, so the bits never tear
      if (c_ff.s2 == c_ff.s1) begin
         nxt_c.s3 = c_ff.s2;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         c_ff <= '0;
      end else begin
         c_ff <= nxt_c;
      end
   end

   assign cmd_ff           = r_ff.cmd;
   assign cmd_bank_ff      = r_ff.bank;
   assign cfg_write_ff     = r_ff.cfg_wr;
   assign cfg_sel_ff       = r_ff.cfg_sel;
   assign array_refresh_ff = r_ff.refresh;
   assign beat_word_ff     = r_ff.word;
   assign beat_valid_ff    = r_ff.word_valid;
   assign data_hiz_ff      = r_ff.data_hiz;
   assign wr_core_start_ff = r_ff.wr_core_start;
   assign term_active_ff   = r_ff.term;
   assign status_ff        = c_ff.s3;

   // ****************
   // Checks
   // ****************
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (lrst);

   sequence burst_run;
      r_ff.busy [*8];
   endsequence

   burst_complete_a: assert property ($rose(r_ff.busy) |-> burst_run)
      else $error("burst ended early");
   rdwr_decode_a: assert property (r_ff.prev_gate && r_ff.pins.clock_gate &&
      !r_ff.pins.cs_n && r_ff.pins.row_open_flag_n && r_ff.pins.ras_a16 &&
      !r_ff.pins.cas_a15 |-> (cmd == sdc_pkg::CMD_RD || cmd == sdc_pkg::CMD_WR))
      else $error("read or write not decoded");
   row_open_a: assert property (cmd == sdc_pkg::CMD_ACT |=> r_ff.banks != 16'h0000)
      else $error("activate opened no bank");
   chop_pick_a: assert property (ld && r_ff.cfg_s2.burst_len_mode == sdc_pkg::BL_OTF
      |=> r_ff.chop == !$past(r_ff.pins.chop_select_bit))
      else $error("chop select ignored");
   cfg_select_a: assert property (cmd == sdc_pkg::CMD_CFG |=> r_ff.cfg_wr &&
      r_ff.cfg_sel == $past({r_ff.pins.group_pick[0], r_ff.pins.bank_slot}))
      else $error("config select wrong");
   close_all_a: assert property (cmd == sdc_pkg::CMD_CLOSE_ALL_ROWS |=> r_ff.banks == 16'h0000)
      else $error("close all left a bank open");
   pd_refresh_a: assert property (r_ff.state == sdc_pkg::ST_PD |-> !r_ff.refresh)
      else $error("refresh during power-down");
   sr_term_a: assert property (r_ff.state == sdc_pkg::ST_SELF_REF |-> !r_ff.term)
      else $error("termination in self refresh");
   sr_entry_a: assert property (cmd == sdc_pkg::CMD_SRE && !idle_now |=>
      r_ff.state != sdc_pkg::ST_SELF_REF)
      else $error("self refresh from non-idle");
   sr_exit_a: assert property (cmd == sdc_pkg::CMD_SRX |=> !r_ff.idle &&
      r_ff.state != sdc_pkg::ST_SELF_REF && r_ff.timer == sdc_pkg::SR_EXIT_CYC)
      else $error("self refresh exit delay skipped");
   il_order_a: assert property (r_ff.busy && r_ff.interleave && !r_ff.is_wr |=>
      r_ff.word == ($past(r_ff.start) ^ $past(r_ff.beat)))
      else $error("interleaved order wrong");
   chop_hiz_a: assert property (r_ff.busy && r_ff.chop && !r_ff.is_wr && r_ff.beat[2]
      |=> r_ff.data_hiz && !r_ff.word_valid)
      else $error("chopped tail not high impedance");
endmodule : sdc_cmd_decode

// ===== sim/sdc_ctrl_model.sv
`timescale 1ns/1ns
module sdc_ctrl_model #(
   parameter int HOLD_CYC = 3
) (
   input  wire logic          link_clk,
   output sdc_pkg::sdc_pins_t pins
);
   // ****************
   // Controller side
   // ****************
   // Released address lines show the inverse of the argument, so set_gate brings back the last command's lines with chip select high
   function automatic sdc_pkg::sdc_pins_t desel(input sdc_pkg::sdc_pins_t p, input logic g);
      desel = ~p;
      desel.cs_n = 1'h1;
      desel.clock_gate = g;
      desel.termination_control = p.termination_control;
   endfunction : desel

   initial begin
      pins = '0;
      pins.cs_n = 1'h1;
      pins.clock_gate = 1'h1;
   end

   task automatic send(input sdc_pkg::sdc_pins_t p);
      @(posedge link_clk);
      pins <= p;
      @(posedge link_clk);
      pins <= desel(p, p.clock_gate);
   endtask : send

   // Gate moves with deselect only, then is held
   task automatic set_gate(input logic g);
      @(posedge link_clk);
      pins <= desel(pins, g);
      repeat (HOLD_CYC) @(posedge link_clk);
   endtask : set_gate
endmodule : sdc_ctrl_model

// ===== sim/sdc_cmd_decode_bench.sv
`timescale 1ns/1ns
module sdc_cmd_decode_bench;
   // ****************
   // Clocks and instances
   // ****************
   logic                 clk;
   logic                 link_clk;
   logic                 rst;
   logic                 reset_n;
   logic                 term_on;
   int                   err_count;
   int                   check_count;
   sdc_pkg::sdc_pins_t   pins;
   sdc_pkg::sdc_cfg_t    cfg;
   sdc_pkg::sdc_cmd_t    cmd_ff;
   logic [3:0]           cmd_bank_ff;
   logic                 cfg_write_ff;
   logic [2:0]           cfg_sel_ff;
   logic                 array_refresh_ff;
   logic [2:0]           beat_word_ff;
   logic                 beat_valid_ff;
   logic                 data_hiz_ff;
   logic                 wr_core_start_ff;
   logic                 term_active_ff;
   sdc_pkg::sdc_status_t status_ff;

   always #50 clk = ~clk;

   initial begin
      link_clk = 1'h0;
      #7;
      forever #24 link_clk = ~link_clk;
   end

   sdc_cmd_decode u_dut (
      .clk(clk), .rst(rst), .link_clk(link_clk), .reset_n(reset_n), .pins(pins), .cfg(cfg),
      .cmd_ff(cmd_ff), .cmd_bank_ff(cmd_bank_ff), .cfg_write_ff(cfg_write_ff),
      .cfg_sel_ff(cfg_sel_ff), .array_refresh_ff(array_refresh_ff),
      .beat_word_ff(beat_word_ff), .beat_valid_ff(beat_valid_ff), .data_hiz_ff(data_hiz_ff),
      .wr_core_start_ff(wr_core_start_ff), .term_active_ff(term_active_ff),
      .status_ff(status_ff)
   );

   sdc_ctrl_model u_ctrl (
      .link_clk(link_clk),
      .pins(pins)
   );

   // ****************
   // Shared tasks
   // ****************
   task automatic give_verdict;
      $display("Checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   function automatic sdc_pkg::sdc_pins_t mk(input logic fl_n, input logic [2:0] op,
         input logic g, input logic [3:0] bk, input logic ap, input logic bc,
         input logic [2:0] col);
      mk = {1'h0, fl_n, op, g, bk, ap, bc, col, term_on};
   endfunction : mk

   task automatic wait_cmd(input sdc_pkg::sdc_cmd_t exp, output logic fw, output logic fr);
      logic hit;
      hit = 1'h0;
      fw = 1'h0;
      fr = 1'h0;
      for (int n = 0; n < 6 && !hit; n++) begin
         @(negedge link_clk);
         fw |= cfg_write_ff;
         fr |= array_refresh_ff;
         hit = cmd_ff === exp;
      end
      chk("cmd", 8'(cmd_ff), 8'(exp));
      if (!hit) give_verdict();
   endtask : wait_cmd

   // Cycles with any decode activity other than none or deselect
   task automatic quiet(output int q);
      q = 0;
      repeat (8) begin
         @(negedge link_clk);
         if (cmd_ff !== sdc_pkg::CMD_NONE && cmd_ff !== sdc_pkg::CMD_DESEL) q++;
         if ({array_refresh_ff, cfg_write_ff, beat_valid_ff} !== 3'h0) q++;
      end
   endtask : quiet

   task automatic settle;
      repeat (8) @(negedge clk);
   endtask : settle

   // ****************
   // Scenarios
   // ****************
   task automatic one(input logic fl_n, input logic [2:0] op, input logic ap,
         input sdc_pkg::sdc_cmd_t exp, input logic [3:0] bk);
      logic fw, fr;
      u_ctrl.send(mk(fl_n, op, 1'h1, bk, ap, 1'h0, 3'h0));
      wait_cmd(exp, fw, fr);
      @(negedge link_clk);
      fw |= cfg_write_ff;
      fr |= array_refresh_ff;
      chk("cfg_write", 8'(fw), 8'(exp == sdc_pkg::CMD_CFG));
      chk("refresh", 8'(fr), 8'(exp == sdc_pkg::CMD_REF));
      chk("bank", 8'(cmd_bank_ff), 8'(bk));
      if (exp == sdc_pkg::CMD_CFG) chk("cfg_sel", 8'(cfg_sel_ff), 8'(bk[2:0]));
      repeat (6) @(negedge link_clk);
   endtask : one

   task automatic t_decode;
      int q;
      one(1'h1, sdc_pkg::OP_CFG, 1'h0, sdc_pkg::CMD_CFG, 4'hD);
      one(1'h1, sdc_pkg::OP_PRE, 1'h0, sdc_pkg::CMD_PRE, 4'h6);
      one(1'h1, sdc_pkg::OP_PRE, 1'h1, sdc_pkg::CMD_CLOSE_ALL_ROWS, 4'h9);
      one(1'h0, sdc_pkg::OP_RD, 1'h0, sdc_pkg::CMD_ACT, 4'hA);
      one(1'h1, sdc_pkg::OP_IDLE, 1'h0, sdc_pkg::CMD_IDLE, 4'h3);
      one(1'h1, sdc_pkg::OP_ZQ, 1'h1, sdc_pkg::CMD_ZQL, 4'h5);
      one(1'h1, sdc_pkg::OP_ZQ, 1'h0, sdc_pkg::CMD_ZQS, 4'hC);
      one(1'h1, sdc_pkg::OP_REF, 1'h0, sdc_pkg::CMD_REF, 4'h1);
      u_ctrl.send(mk(1'h1, 3'h3, 1'h1, 4'h0, 1'h0, 1'h0, 3'h0));
      quiet(q);
      chk("reserved_op", 8'(q), 8'h00);
   endtask : t_decode

   task automatic burst(input logic wr, input logic [1:0] md, input logic il,
         input logic bc, input logic [2:0] s, input logic dbl, output int wr_at);
      logic       ch, fw, fr, off;
      logic [2:0] w;
      int         extra;
      ch = md == sdc_pkg::BL_FIXED4 || (md == sdc_pkg::BL_OTF && !bc);
      wr_at = -1;
      extra = 0;
      @(posedge clk);
      cfg <= {il, md};
      repeat (4) @(posedge clk);
      // Second read lands mid-burst and must be dropped
      fork
         if (dbl) begin
            repeat (3) @(posedge link_clk);
            u_ctrl.send(mk(1'h1, sdc_pkg::OP_RD, 1'h1, 4'h0, 1'h0, 1'h1, ~s));
         end
      join_none
      u_ctrl.send(mk(1'h1, wr ? sdc_pkg::OP_WR : sdc_pkg::OP_RD, 1'h1, 4'h6, 1'h0, bc, s));
      wait_cmd(wr ? sdc_pkg::CMD_WR : sdc_pkg::CMD_RD, fw, fr);
      for (int i = 0; i < 12; i++) begin
         @(negedge link_clk);
         off = ch && i > 3;
         w = wr ? (ch ? {s[2], i[1:0]} : i[2:0])
            : il ? (ch ? {s[2], s[1:0] ^ i[1:0]} : s ^ i[2:0])
            : {s[2] ^ (i[2] & !ch), s[1:0] + i[1:0]};
         if (i < 8) begin
            chk("valid", 8'(beat_valid_ff), 8'(!off));
            if (!off) chk("word", 8'(beat_word_ff), 8'(w));
            if (!wr) chk("hiz", 8'(data_hiz_ff), 8'(off));
         end
         if (wr_core_start_ff === 1'h1 && wr_at < 0) wr_at = i;
         // A dropped second request leaves no beats behind the first burst
         if (i > 7 && {beat_valid_ff, data_hiz_ff} !== 2'h0) extra++;
      end
      chk("extra_cmd", 8'(extra), 8'h00);
   endtask : burst

   task automatic t_bursts;
      int a, b, c;
      for (int s = 0; s < 16; s++) begin
         burst(1'h0, sdc_pkg::BL_FIXED8, s[3], 1'h0, s[2:0], 1'h0, a);
         burst(1'h0, sdc_pkg::BL_FIXED4, s[3], 1'h0, s[2:0], 1'h0, a);
      end
      burst(1'h0, sdc_pkg::BL_OTF, 1'h1, 1'h0, 3'h6, 1'h1, a);
      burst(1'h0, sdc_pkg::BL_OTF, 1'h0, 1'h1, 3'h3, 1'h0, a);
      burst(1'h1, sdc_pkg::BL_FIXED8, 1'h0, 1'h0, 3'h5, 1'h0, a);
      burst(1'h1, sdc_pkg::BL_OTF, 1'h1, 1'h0, 3'h5, 1'h0, b);
      burst(1'h1, sdc_pkg::BL_FIXED4, 1'h0, 1'h0, 3'h7, 1'h0, c);
      chk("wr_start_seen", 8'(a >= 0), 8'h01);
      chk("wr_start_otf", 8'(b), 8'(a));
      chk("wr_start_fix4", 8'(c + 2), 8'(b));
   endtask : t_bursts

   // Status fields: idle, power_down, pd_precharge, self_refresh
   task automatic t_power;
      int q;
      u_ctrl.send(mk(1'h1, sdc_pkg::OP_REF, 1'h0, 4'h2, 1'h0, 1'h0, 3'h0));
      settle();
      chk("act_pd", 8'(status_ff), 8'h04);
      u_ctrl.send(mk(1'h1, sdc_pkg::OP_REF, 1'h0, 4'h2, 1'h0, 1'h0, 3'h0));
      quiet(q);
      chk("pd_refresh", 8'(q), 8'h00);
      u_ctrl.set_gate(1'h1);
      settle();
      chk("pd_exit", 8'(status_ff), 8'h00);
      u_ctrl.send(mk(1'h1, sdc_pkg::OP_PRE, 1'h1, 4'h0, 1'h1, 1'h0, 3'h0));
      settle();
      chk("idle", 8'(status_ff), 8'h08);
      u_ctrl.set_gate(1'h0);
      settle();
      chk("pre_pd", 8'(status_ff), 8'h06);
      u_ctrl.set_gate(1'h1);
      settle();
      term_on = 1'h1;
      u_ctrl.send(mk(1'h1, sdc_pkg::OP_IDLE, 1'h1, 4'h0, 1'h0, 1'h0, 3'h0));
      settle();
      chk("term", 8'(term_active_ff), 8'h01);
      u_ctrl.send(mk(1'h1, sdc_pkg::OP_REF, 1'h0, 4'h0, 1'h0, 1'h0, 3'h0));
      settle();
      chk("self_ref", 8'(status_ff), 8'h01);
      chk("term_sr", 8'(term_active_ff), 8'h00);
      u_ctrl.set_gate(1'h1);
      settle();
      chk("sr_exit", 8'(status_ff), 8'h08);
      u_ctrl.send(mk(1'h1, sdc_pkg::OP_REF, 1'h0, 4'h0, 1'h0, 1'h0, 3'h0));
      settle();
      chk("sr_again", 8'(status_ff), 8'h01);
      u_ctrl.send(mk(1'h1, sdc_pkg::OP_IDLE, 1'h1, 4'h0, 1'h0, 1'h0, 3'h0));
      settle();
      chk("sr_exit_idle_cmd", 8'(status_ff), 8'h08);
      term_on = 1'h0;
   endtask : t_power

   // Pin reset in mid-run closes open banks
   task automatic t_pin_reset;
      one(1'h0, sdc_pkg::OP_RD, 1'h0, sdc_pkg::CMD_ACT, 4'h4);
      settle();
      chk("row_open", 8'(status_ff), 8'h00);
      @(posedge clk);
      reset_n <= 1'h0;
      @(posedge clk);
      reset_n <= 1'h1;
      settle();
      chk("pin_reset", 8'(status_ff), 8'h08);
   endtask : t_pin_reset

   initial begin
      clk = 1'h0;
      rst = 1'h1;
      reset_n = 1'h1;
      term_on = 1'h0;
      err_count = 0;
      check_count = 0;
      cfg = '0;
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      repeat (4) @(posedge clk);
      t_decode();
      t_bursts();
      t_power();
      t_pin_reset();
      give_verdict();
   end
endmodule : sdc_cmd_decode_bench
